/* mcuirq_core_model.sv */
// Behavioural core sequencer: issues instruction strobes and takes vectors
`timescale 1ns/1ps
`default_nettype none
module mcuirq_core_model (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// Block side
	input  wire logic                  vec_valid_in,
	input  wire logic [10:0]           vec_addr_in,
	output var mcuirq_pkg::mcuirq_instr_t instr_out
);
	import mcuirq_pkg::*;
	int          n_vec;
	logic [10:0] last_vec;
	logic        last_eni;
	initial instr_out = '0;
	initial last_eni = 1'b0;
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			n_vec <= 0;
		else if (vec_valid_in)
		begin
			n_vec    <= n_vec + 1;
			last_vec <= vec_addr_in;
		end
	end
	// Index 0..4 is eni, disable_irqs_instr, return_from_irq_instr, swi, clear_watchdog_instr
	task automatic issue(input int k);
		// Idle slot so a return never directly follows an enable
		if (k == 2 && last_eni)
			@(posedge clk_in);
		@(posedge clk_in);
		instr_out <= mcuirq_instr_t'(5'h10 >> k);
		@(posedge clk_in);
		instr_out <= '0;
		last_eni = (k == 0);
	endtask : issue
endmodule : mcuirq_core_model
`default_nettype wire

/* mcuirq_pkg.sv */
// Constants and types shared by the interrupt and watchdog flag block
package mcuirq_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Register offsets
	localparam logic [7:0] IRQ_FLAG_OFS   = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_OFS = 8'h01;
	localparam logic [7:0] PWR_CTRL_OFS   = 8'h02;
	localparam logic [7:0] PWR_CTRL2_OFS  = 8'h03;
	localparam logic [7:0] STATUS_OFS     = 8'h04;
	localparam logic [7:0] PRESCALE_OFS   = 8'h05;
	localparam logic [7:0] EXT_CFG_OFS    = 8'h06;
	localparam logic [7:0] WAKE_SEL_OFS   = 8'h07;
	localparam logic [7:0] LV_THRESH_OFS  = 8'h08;
	// Flag and enable bit positions
	localparam int T0_BIT   = 0;
	localparam int PB_BIT   = 1;
	localparam int EXT_BIT  = 2;
	localparam int T1_BIT   = 3;
	localparam int WDT_BIT  = 6;
	localparam int LVD_BIT  = 7;
	localparam logic [7:0] FLAG_MASK = 8'hcf;
	// Other field positions
	localparam int WDT_RUN_BIT  = 7;
	localparam int LVD_ON_BIT   = 5;
	localparam int LV_LIVE_BIT  = 6;
	localparam int TO_N_BIT     = 4;
	localparam int PS_WDT_BIT   = 3;
	localparam int EIS_BIT      = 0;
	localparam int EDGE_POL_BIT = 1;
	localparam int PB_PINS      = 6;
	// Reset values
	localparam logic [7:0] PWR_CTRL_RST = 8'h80;
	localparam logic [7:0] PRESCALE_RST = 8'h00;
	// Vectors
	localparam logic [10:0] SWI_VECTOR = 11'h001;
	localparam logic [10:0] HW_VECTOR  = 11'h008;
	// Watchdog base periods
	localparam real WDT_P0_MS = 3.5;
	localparam real WDT_P1_MS = 15.0;
	localparam real WDT_P2_MS = 60.0;
	localparam real WDT_P3_MS = 250.0;
	localparam int  WDT_P0_CYC = int'(WDT_P0_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int  WDT_P1_CYC = int'(WDT_P1_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int  WDT_P2_CYC = int'(WDT_P2_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int  WDT_P3_CYC = int'(WDT_P3_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int  WDT_CNT_W  = 25;

	// One-cycle instruction strobes from the core sequencer
	typedef struct packed {
		logic enable_irqs_instr;
		logic disable_irqs_instr;
		logic return_from_irq_instr;
		logic swi;
		logic clear_watchdog_instr;
	} mcuirq_instr_t;
endpackage : mcuirq_pkg

/* mcuirq_top.sv */
// Interrupt flags, global enable, watchdog and low-voltage flag logic
// Notes on behaviour
// R1: Hardware interrupts need global enable; instructions set/clear
// R2: Software interrupt vectors to 0x001, clears enable
// R3: Return instruction sets global enable again
// R4: Event flags stay set until written zero
// R5: Flag reads show only enabled bits
// R6: Enabled pending flag vectors to 0x008, clears enable
// R7: Enable instruction inside routine allows nesting
// R8: Firmware avoids enable right before return
// R9: Timer0 wrap sets flag bit 0
// R10: Timer1 underflow sets flag bit 3
// R11: Watchdog timeout in interrupt mode sets bit 6
// R12: Watchdog timeout resets or interrupts, clears status
// R13: Clear-watchdog clears counter, prescaler, sets status; here only while prescaler bit 3 assigns it to the watchdog
// R14: Runtime bit 7 gates configured watchdog
// R15: Base timeout 3.5, 15, 60, 250 ms
// R16: Prescaler ratios 1:1-1:128 reset, 1:2-1:256 interrupt
// R17: Port-B input level change sets change flag
// R18: External select masks pin 0 change detection
// R19: Chosen pin 0 edge sets external flag
// R20: Low-voltage output falling edge sets flag
// R21: Detector runs on bit 5; live state readable
// R22: Firmware waits 50us after threshold change
// R23: Timer0 flag and enable at bit 0
// R24: Timer1 flag and enable at bit 3
// R25: Request is OR of enabled flags, no priority
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module mcuirq_top #(
	parameter int WDT_P0 = mcuirq_pkg::WDT_P0_CYC,
	parameter int WDT_P1 = mcuirq_pkg::WDT_P1_CYC,
	parameter int WDT_P2 = mcuirq_pkg::WDT_P2_CYC,
	parameter int WDT_P3 = mcuirq_pkg::WDT_P3_CYC
) (
	// Clock and reset
	input  wire logic                      clk_in,
	input  wire logic                      rst_in,
	// Register port
	input  wire logic [7:0]                reg_addr_in,
	input  wire logic [7:0]                reg_wdata_in,
	input  wire logic                      reg_wr_in,
	input  wire logic                      reg_rd_in,
	output logic      [7:0]                reg_rdata_out,
	// Core sequencer
	input  wire mcuirq_pkg::mcuirq_instr_t instr_in,
	output logic                           irq_req_out,
	output logic                           global_irq_enable_out,
	output logic                           vec_valid_out,
	output logic      [10:0]               vec_addr_out,
	output logic                           wdt_reset_out,
	// Event sources
	input  wire logic                      timer0_wrap_in,
	input  wire logic                      timer1_under_in,
	input  wire logic [5:0]                portb_pins_in,
	input  wire logic [5:0]                portb_is_input_in,
	input  wire logic                      lv_detect_in,
	output logic                           low_voltage_detect_on_out,
	output logic      [3:0]                lv_thresh_sel_out,
	// Configuration words
	input  wire logic                      wdt_cfg_enable_in,
	input  wire logic                      wdt_cfg_irq_mode_in,
	input  wire logic [1:0]                wdt_period_sel_in
);
	import mcuirq_pkg::*;

	logic [7:0]           irq_flag_reg_q;
	logic [7:0]           irq_enable_reg_q;
	logic [7:0]           power_control_reg_q;
	logic [7:0]           prescale_q;
	logic [1:0]           ext_cfg_q;
	logic [5:0]           portb_wake_select_q;
	logic [3:0]           lv_thresh_q;
	logic                 timeout_status_n_q;
	logic                 global_irq_enable_q;
	logic [7:0]           rdata_q;
	logic                 vec_valid_q;
	logic [10:0]          vec_addr_q;
	logic                 wdt_reset_q;
	logic [5:0]           pb_meta_q;
	logic [5:0]           pb_sync_q;
	logic [5:0]           pb_prev_q;
	logic                 lv_meta_q;
	logic                 lv_sync_q;
	logic                 lv_prev_q;
	logic [WDT_CNT_W-1:0] wdt_cnt_q;
	logic [7:0]           wdt_ps_q;
	logic [WDT_CNT_W-1:0] wdt_limit;
	logic [7:0]           ps_ratio;
	logic [7:0]           flag_set;
	logic [5:0]           pb_mask;
	logic                 wr_flag;
	logic                 hw_take;
	logic                 base_tick;
	logic                 wdt_run;
	logic                 wdt_timeout;
	logic                 ps_to_wdt;
	logic                 ext_edge;

	assign wr_flag = reg_wr_in && (reg_addr_in == IRQ_FLAG_OFS);

	// Pin inputs are asynchronous; two flops before any use
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			pb_meta_q <= 6'h00;
			pb_sync_q <= 6'h00;
			pb_prev_q <= 6'h00;
			lv_meta_q <= 1'b1;
			lv_sync_q <= 1'b1;
			lv_prev_q <= 1'b1;
		end
		else
		begin
			pb_meta_q <= portb_pins_in;
			pb_sync_q <= pb_meta_q;
			pb_prev_q <= pb_sync_q;
			lv_meta_q <= lv_detect_in;
			lv_sync_q <= lv_meta_q;
			lv_prev_q <= lv_sync_q;
		end
	end

	// Pin 0 belongs to the edge interrupt while selected
	always_comb
	begin
		pb_mask = portb_is_input_in & portb_wake_select_q; // R17
		if (ext_cfg_q[EIS_BIT])
			pb_mask[0] = 1'b0; // R18
	end

	// Polarity 1 picks the rising edge
	assign ext_edge = ext_cfg_q[EIS_BIT] && (pb_sync_q[0] != pb_prev_q[0])
		&& (pb_sync_q[0] == ext_cfg_q[EDGE_POL_BIT]); // R19

	always_comb
	begin
		flag_set          = 8'h00;
		flag_set[T0_BIT]  = timer0_wrap_in; // R9 R23
		flag_set[T1_BIT]  = timer1_under_in; // R10 R24
		flag_set[WDT_BIT] = wdt_timeout && wdt_cfg_irq_mode_in; // R11
		flag_set[PB_BIT]  = |((pb_sync_q ^ pb_prev_q) & pb_mask); // R17
		flag_set[EXT_BIT] = ext_edge; // R19
		flag_set[LVD_BIT] = power_control_reg_q[LVD_ON_BIT] && lv_prev_q && !lv_sync_q; // R20
	end

	// Writing 1 leaves a flag alone; a same-cycle event wins over the clear
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			irq_flag_reg_q <= 8'h00;
		else if (wr_flag)
			irq_flag_reg_q <= ((irq_flag_reg_q & reg_wdata_in) | flag_set) & FLAG_MASK; // R4
		else
			irq_flag_reg_q <= irq_flag_reg_q | flag_set; // R4
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			irq_enable_reg_q    <= 8'h00;
			power_control_reg_q <= PWR_CTRL_RST;
			prescale_q          <= PRESCALE_RST;
			ext_cfg_q           <= 2'b00;
			portb_wake_select_q <= 6'h00;
			lv_thresh_q         <= 4'h0;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				IRQ_ENABLE_OFS: irq_enable_reg_q    <= reg_wdata_in & FLAG_MASK;
				PWR_CTRL_OFS:   power_control_reg_q <= reg_wdata_in;
				PRESCALE_OFS:   prescale_q          <= reg_wdata_in & 8'h0f;
				EXT_CFG_OFS:    ext_cfg_q           <= reg_wdata_in[1:0];
				WAKE_SEL_OFS:   portb_wake_select_q <= reg_wdata_in[5:0];
				LV_THRESH_OFS:  lv_thresh_q         <= reg_wdata_in[3:0];
				default:        ;
			endcase
		end
	end

	// No hardware priority; software polls the flags
	assign irq_req_out = |(irq_flag_reg_q & irq_enable_reg_q); // R25
	assign hw_take = irq_req_out && global_irq_enable_q && !instr_in.swi; // R1 R6

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			global_irq_enable_q <= 1'b0;
		else if (instr_in.swi || hw_take || instr_in.disable_irqs_instr)
			global_irq_enable_q <= 1'b0; // R1 R2 R6
		else if (instr_in.enable_irqs_instr || instr_in.return_from_irq_instr)
			global_irq_enable_q <= 1'b1; // R1 R3 R7
	end

	// Software vector goes out whatever the global enable
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			vec_valid_q <= 1'b0;
			vec_addr_q  <= 11'h000;
		end
		else
		begin
			vec_valid_q <= instr_in.swi || hw_take;
			if (instr_in.swi)
				vec_addr_q <= SWI_VECTOR; // R2
			else if (hw_take)
				vec_addr_q <= HW_VECTOR; // R6
		end
	end

	always_comb
	begin
		case (wdt_period_sel_in)
			2'd0:    wdt_limit = WDT_CNT_W'(WDT_P0 - 1); // R15
			2'd1:    wdt_limit = WDT_CNT_W'(WDT_P1 - 1);
			2'd2:    wdt_limit = WDT_CNT_W'(WDT_P2 - 1);
			default: wdt_limit = WDT_CNT_W'(WDT_P3 - 1);
		endcase
	end

	assign ps_to_wdt = prescale_q[PS_WDT_BIT];
	assign wdt_run   = wdt_cfg_enable_in && power_control_reg_q[WDT_RUN_BIT]; // R14
	assign base_tick = wdt_run && (wdt_cnt_q >= wdt_limit);
	// Ratio minus one: 2^sel in reset mode, 2^(sel+1) in interrupt mode
	assign ps_ratio = !ps_to_wdt ? 8'h00 :
		(wdt_cfg_irq_mode_in ? ((8'h02 << prescale_q[2:0]) - 8'h01)
		: ((8'h01 << prescale_q[2:0]) - 8'h01)); // R16
	assign wdt_timeout = base_tick && (wdt_ps_q >= ps_ratio);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wdt_cnt_q <= '0;
			wdt_ps_q  <= 8'h00;
		end
		else if ((instr_in.clear_watchdog_instr && ps_to_wdt) || !wdt_run)
		begin
			wdt_cnt_q <= '0; // R13
			wdt_ps_q  <= 8'h00;
		end
		else if (base_tick)
		begin
			wdt_cnt_q <= '0;
			wdt_ps_q  <= wdt_timeout ? 8'h00 : wdt_ps_q + 8'h01;
		end
		else
			wdt_cnt_q <= wdt_cnt_q + 1'b1;
	end

	// Timeout clears the status even if a clear arrives together
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			timeout_status_n_q <= 1'b1;
			wdt_reset_q        <= 1'b0;
		end
		else
		begin
			wdt_reset_q <= wdt_timeout && !wdt_cfg_irq_mode_in; // R12
			if (wdt_timeout)
				timeout_status_n_q <= 1'b0; // R12
			else if (instr_in.clear_watchdog_instr && ps_to_wdt)
				timeout_status_n_q <= 1'b1; // R13
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				IRQ_FLAG_OFS:   rdata_q <= irq_flag_reg_q & irq_enable_reg_q; // R5
				IRQ_ENABLE_OFS: rdata_q <= irq_enable_reg_q;
				PWR_CTRL_OFS:   rdata_q <= power_control_reg_q;
				PWR_CTRL2_OFS:  rdata_q <= {1'b0, lv_sync_q, 6'h00}; // R21
				STATUS_OFS:     rdata_q <= {3'b000, timeout_status_n_q, 4'h0};
				PRESCALE_OFS:   rdata_q <= prescale_q;
				EXT_CFG_OFS:    rdata_q <= {6'h00, ext_cfg_q};
				WAKE_SEL_OFS:   rdata_q <= {2'b00, portb_wake_select_q};
				LV_THRESH_OFS:  rdata_q <= {4'h0, lv_thresh_q};
				default:        rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end

	assign reg_rdata_out             = rdata_q;
	assign global_irq_enable_out     = global_irq_enable_q;
	assign vec_valid_out             = vec_valid_q;
	assign vec_addr_out              = vec_addr_q;
	assign wdt_reset_out             = wdt_reset_q;
	assign low_voltage_detect_on_out = power_control_reg_q[LVD_ON_BIT]; // R21
	assign lv_thresh_sel_out         = lv_thresh_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	chk_flag_sticky: assert property ( // R4
		irq_flag_reg_q[T0_BIT] && !wr_flag |=> irq_flag_reg_q[T0_BIT])
		else $error("flag dropped without a write");
	chk_flag_read_mask: assert property ( // R5
		reg_rd_in && reg_addr_in == IRQ_FLAG_OFS
		|=> reg_rdata_out == ($past(irq_flag_reg_q) & $past(irq_enable_reg_q)))
		else $error("flag read not masked by enables");
	chk_swi_vector: assert property ( // R2
		instr_in.swi |=> vec_valid_out && vec_addr_out == SWI_VECTOR && !global_irq_enable_out)
		else $error("software vector wrong");
	chk_hw_vector: assert property ( // R6
		irq_req_out && global_irq_enable_out && !instr_in.swi
		|=> vec_valid_out && vec_addr_out == HW_VECTOR && !global_irq_enable_out)
		else $error("hardware vector wrong");
	chk_eni_sets: assert property ( // R1
		instr_in.enable_irqs_instr && !instr_in.disable_irqs_instr && !instr_in.swi && !hw_take |=> global_irq_enable_out)
		else $error("enable instruction ignored");
	chk_return_sets: assert property ( // R3
		instr_in.return_from_irq_instr && !instr_in.disable_irqs_instr && !instr_in.swi && !hw_take |=> global_irq_enable_out)
		else $error("return did not restore enable");
	chk_t0_flag: assert property ( // R9
		timer0_wrap_in |=> irq_flag_reg_q[T0_BIT])
		else $error("timer0 flag not set");
	chk_t1_flag: assert property ( // R10
		timer1_under_in |=> irq_flag_reg_q[T1_BIT])
		else $error("timer1 flag not set");
	chk_wdt_status: assert property ( // R12
		wdt_timeout |=> !timeout_status_n_q && (wdt_reset_out == !$past(wdt_cfg_irq_mode_in)))
		else $error("watchdog timeout effects wrong");
	chk_clear_watchdog_instr_effect: assert property ( // R13
		instr_in.clear_watchdog_instr && ps_to_wdt && !wdt_timeout |=> timeout_status_n_q && wdt_cnt_q == '0)
		else $error("clear watchdog had no effect");
endmodule : mcuirq_top
`default_nettype wire

/* mcuirq_top_tb.sv */
// Self-checking bench for the interrupt and watchdog flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module mcuirq_top_tb;
	import mcuirq_pkg::*;
	localparam int WP [4] = '{8, 12, 16, 20};
	logic          clk_in, rst_in, reg_wr, reg_rd, t0, t1, lv, cfg_en, cfg_irq;
	logic          irq_req, global_irq_enable, vv, wdt_rst, lvd_on;
	logic [7:0]    reg_addr, reg_wdata, rdata_out, d;
	logic [5:0]    pins, is_in;
	logic [1:0]    psel;
	logic [10:0]   vaddr;
	logic [3:0]    thr;
	mcuirq_instr_t instr;
	int            fails = 0, n_checks = 0, cyc = 0, gap, n0;

	mcuirq_top #(.WDT_P0(WP[0]), .WDT_P1(WP[1]), .WDT_P2(WP[2]), .WDT_P3(WP[3])) uut (
		.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata_out), .instr_in(instr),
		.irq_req_out(irq_req), .global_irq_enable_out(global_irq_enable), .vec_valid_out(vv), .vec_addr_out(vaddr),
		.wdt_reset_out(wdt_rst), .timer0_wrap_in(t0), .timer1_under_in(t1), .portb_pins_in(pins),
		.portb_is_input_in(is_in), .lv_detect_in(lv), .low_voltage_detect_on_out(lvd_on),
		.lv_thresh_sel_out(thr), .wdt_cfg_enable_in(cfg_en), .wdt_cfg_irq_mode_in(cfg_irq),
		.wdt_period_sel_in(psel));
	mcuirq_core_model core (.clk_in(clk_in), .rst_in(rst_in), .vec_valid_in(vv), .vec_addr_in(vaddr),
		.instr_out(instr));

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Whole run needs about 5400 cycles
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			summarize();
		end
	end

	task automatic summarize();
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_in);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1 d = rdata_out;
		`CHK(nm, e, d & m)
	endtask : chk_rd
	task automatic ev(input int k);
		@(posedge clk_in);
		t0 <= (k == 0);
		t1 <= (k == 1);
		@(posedge clk_in);
		t0 <= 1'b0;
		t1 <= 1'b0;
	endtask : ev
	// Syncs on one reset pulse, then counts edges to the next
	task automatic gap_of(output int n);
		for (int i = 0; i < 2; i++)
		begin
			n = 0;
			do
			begin
				@(posedge clk_in);
				#1 n++;
			end
			while (!wdt_rst && n < 600);
		end
	endtask : gap_of

	initial
	begin
		rst_in = 1'b1;
		{reg_wr, reg_rd, t0, t1, cfg_en, psel} = '0;
		{reg_addr, reg_wdata, pins} = '0;
		{lv, cfg_irq, is_in} = 8'hff;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		#1 `CHK("gie_rst", 1'b0, global_irq_enable)
		chk_rd("pwr_ctrl", PWR_CTRL_OFS, 8'hff, PWR_CTRL_RST);
		chk_rd("timeout_n", STATUS_OFS, 8'h10, 8'h10);
		ev(0);
		chk_rd("masked", IRQ_FLAG_OFS, 8'hff, 8'h00);
		wr(IRQ_ENABLE_OFS, FLAG_MASK);
		chk_rd("t0_flag", IRQ_FLAG_OFS, 8'hff, 8'h01);
		ev(1);
		chk_rd("t1_flag", IRQ_FLAG_OFS, 8'hff, 8'h09);
		`CHK("irq_req", 1'b1, irq_req)
		wr(IRQ_FLAG_OFS, 8'hfe);
		chk_rd("clear0", IRQ_FLAG_OFS, 8'hff, 8'h08);
		chk_rd("unmapped", 8'h3c, 8'hff, 8'h00);
		n0 = core.n_vec;
		repeat (4) @(posedge clk_in);
		`CHK("no_take", n0, core.n_vec)
		core.issue(0);
		repeat (3) @(posedge clk_in);
		#1 `CHK("hw_take", n0 + 1, core.n_vec)
		`CHK("hw_vec", HW_VECTOR, core.last_vec)
		`CHK("gie_hw", 1'b0, global_irq_enable)
		core.issue(0);
		repeat (3) @(posedge clk_in);
		#1 `CHK("nested", n0 + 2, core.n_vec)
		wr(IRQ_FLAG_OFS, 8'h00);
		core.issue(2);
		#1 `CHK("gie_ret", 1'b1, global_irq_enable)
		core.issue(1);
		#1 `CHK("gie_dis", 1'b0, global_irq_enable)
		core.issue(3);
		repeat (2) @(posedge clk_in);
		#1 `CHK("sw_take", n0 + 3, core.n_vec)
		`CHK("sw_vec", SWI_VECTOR, core.last_vec)
		`CHK("gie_sw", 1'b0, global_irq_enable)
		core.issue(0);
		#1 `CHK("gie_eni", 1'b1, global_irq_enable)
		core.issue(3);
		#1 `CHK("gie_swi_on", 1'b0, global_irq_enable)
		wr(WAKE_SEL_OFS, 8'h3f);
		wr(IRQ_ENABLE_OFS, 8'h06);
		pins <= 6'h08;
		repeat (5) @(posedge clk_in);
		chk_rd("pb_change", IRQ_FLAG_OFS, 8'hff, 8'h02);
		wr(EXT_CFG_OFS, 8'h03);
		wr(IRQ_FLAG_OFS, 8'h00);
		pins <= 6'h09;
		repeat (5) @(posedge clk_in);
		chk_rd("ext_rise", IRQ_FLAG_OFS, 8'hff, 8'h04);
		wr(IRQ_FLAG_OFS, 8'h00);
		pins <= 6'h08;
		repeat (5) @(posedge clk_in);
		chk_rd("ext_fall", IRQ_FLAG_OFS, 8'hff, 8'h00);
		@(posedge clk_in);
		is_in <= 6'h37;
		pins  <= 6'h00;
		repeat (5) @(posedge clk_in);
		chk_rd("pb_output", IRQ_FLAG_OFS, 8'hff, 8'h00);
		wr(EXT_CFG_OFS, 8'h01);
		pins <= 6'h01;
		repeat (5) @(posedge clk_in);
		pins <= 6'h00;
		repeat (5) @(posedge clk_in);
		chk_rd("ext_fall_sel", IRQ_FLAG_OFS, 8'hff, 8'h04);
		wr(PWR_CTRL_OFS, 8'h20);
		wr(IRQ_ENABLE_OFS, 8'h80);
		wr(LV_THRESH_OFS, 8'h05);
		#1 `CHK("lvd_on", 1'b1, lvd_on)
		`CHK("lv_thresh", 4'h5, thr)
		repeat (5000) @(posedge clk_in);
		lv <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk_rd("lv_flag", IRQ_FLAG_OFS, 8'hff, 8'h80);
		chk_rd("lv_live", PWR_CTRL2_OFS, 8'h40, 8'h00);
		cfg_en <= 1'b1;
		wr(IRQ_ENABLE_OFS, 8'h40);
		wr(IRQ_FLAG_OFS, 8'h00);
		wr(PWR_CTRL_OFS, 8'h80);
		repeat (12) @(posedge clk_in);
		chk_rd("wdt_flag", IRQ_FLAG_OFS, 8'hff, 8'h40);
		chk_rd("to_clear", STATUS_OFS, 8'h10, 8'h00);
		wr(PRESCALE_OFS, 8'h08);
		core.issue(4);
		chk_rd("clear_watchdog_instr", STATUS_OFS, 8'h10, 8'h10);
		wr(PWR_CTRL_OFS, 8'h00);
		wr(IRQ_FLAG_OFS, 8'h00);
		repeat (40) @(posedge clk_in);
		chk_rd("wdt_off", IRQ_FLAG_OFS, 8'hff, 8'h00);
		cfg_irq <= 1'b0;
		wr(PRESCALE_OFS, 8'h00);
		wr(PWR_CTRL_OFS, 8'h80);
		for (int s = 0; s < 4; s++)
		begin
			psel <= s[1:0];
			gap_of(gap);
			`CHK("wdt_period", WP[s], gap)
		end
		chk_rd("to_rst", STATUS_OFS, 8'h10, 8'h00);
		psel <= 2'h0;
		wr(PRESCALE_OFS, 8'h09);
		gap_of(gap);
		`CHK("wdt_ratio", 2 * WP[0], gap)
		summarize();
	end
endmodule : mcuirq_top_tb
`default_nettype wire
